// ---- slohc_pkg.sv ----
// package: states and constants for the second-level over-current hiccup block
package slohc_pkg;
  typedef enum logic [2:0] {
    SLOHC_IDLE,
    SLOHC_WARN,
    SLOHC_LATCHED,
    SLOHC_DISCHARGE,
    SLOHC_RECHARGE
  } slohc_state_t;
  localparam int unsigned SLOHC_SYNC_STAGES = 2;
  localparam int unsigned SLOHC_TRIPS_FOR_FAULT = 2;
  localparam logic        SLOHC_RST_SWITCH_EN = 1'b0;
  localparam logic        SLOHC_RST_STARTUP_EN = 1'b1;
  localparam logic [1:0]  SLOHC_RST_SYNC = 2'h0;
endpackage

// ---- slohc_sync_if.sv ----
// interface: synchronised comparator levels passed to the main block
`timescale 1ns/1ps
interface slohc_sync_if;
  logic trip;
  logic cycle_end;
  logic undervolt;
  logic below_restart;
  logic above_turn_on;
  modport src (output trip, output cycle_end, output undervolt, output below_restart, output above_turn_on);
  modport dst (input trip, input cycle_end, input undervolt, input below_restart, input above_turn_on);
endinterface

// ---- slohc_sync.sv ----
// two-flop synchronisers for the analog comparator inputs
`timescale 1ns/1ps
module slohc_sync
  import slohc_pkg::*;
(
  input  wire logic  clk_in,
  input  wire logic  rst_in,
  input  wire logic  oc2_trip_in,
  input  wire logic  on_time_end_in,
  input  wire logic  undervolt_in,
  input  wire logic  below_restart_in,
  input  wire logic  above_turn_on_in,
  slohc_sync_if.src  sync_if
);
  logic [4:0] stage1_ff;
  logic [4:0] stage2_ff;
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      stage1_ff <= 5'h00;
      stage2_ff <= 5'h00;
    end
    else
    begin
      stage1_ff <= {above_turn_on_in, below_restart_in, undervolt_in, on_time_end_in, oc2_trip_in};
      stage2_ff <= stage1_ff;
    end
  end
  assign sync_if.trip          = stage2_ff[0];
  assign sync_if.cycle_end     = stage2_ff[1];
  assign sync_if.undervolt     = stage2_ff[2];
  assign sync_if.below_restart = stage2_ff[3];
  assign sync_if.above_turn_on = stage2_ff[4];
endmodule

// ---- slohc_top.sv ----
// second-level over-current protection with latched shutdown and hiccup restart
`timescale 1ns/1ps
module slohc_top
  import slohc_pkg::*;
(
  input  wire logic  clk_in,
  input  wire logic  rst_in,
  input  wire logic  oc2_trip_in,
  input  wire logic  on_time_end_in,
  input  wire logic  undervolt_in,
  input  wire logic  below_restart_in,
  input  wire logic  above_turn_on_in,
  output logic       switch_en_out,
  output logic       startup_src_en_out,
  output logic       warning_out,
  output logic       fault_latched_out,
  output logic       trip_flag_out
);
  import slohc_pkg::*;

  slohc_sync_if sync_if ();
  slohc_state_t state_ff;
  slohc_state_t nxt_state;
  logic         cycle_end_d_ff;
  logic         sample;
  logic         switch_en_ff;
  logic         startup_src_en_ff;
  logic         warning_ff;
  logic         fault_latched_ff;
  logic         trip_flag_ff;
  logic [1:0]   trip_run_ff;
  logic [1:0]   nxt_trip_run;

  localparam logic [1:0] TRIP_LIMIT = 2'(SLOHC_TRIPS_FOR_FAULT);

  // states in which the power switch may run
  function automatic logic switching_allowed(input slohc_state_t st);
    return (st == SLOHC_IDLE) || (st == SLOHC_WARN);
  endfunction

  // states in which the start-up source charges the supply
  function automatic logic charging(input slohc_state_t st);
    return st == SLOHC_RECHARGE;
  endfunction

  // shutdown held until the supply collapses
  function automatic logic latched(input slohc_state_t st);
    return st == SLOHC_LATCHED;
  endfunction

  // disturbance filter pending
  function automatic logic warned(input slohc_state_t st);
    return st == SLOHC_WARN;
  endfunction

  slohc_sync u_sync (
    .clk_in           (clk_in),
    .rst_in           (rst_in),
    .oc2_trip_in      (oc2_trip_in),
    .on_time_end_in   (on_time_end_in),
    .undervolt_in     (undervolt_in),
    .below_restart_in (below_restart_in),
    .above_turn_on_in (above_turn_on_in),
    .sync_if          (sync_if)
  );

  // one sample per switching cycle at end of on-time
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      cycle_end_d_ff <= 1'b0;
    else
      cycle_end_d_ff <= sync_if.cycle_end;
  end
  assign sample = sync_if.cycle_end & ~cycle_end_d_ff;

  // run of consecutive sampled trips while switching
  always_comb
  begin
    nxt_trip_run = trip_run_ff;
    if (!switching_allowed(state_ff))
      nxt_trip_run = 2'h0;
    else if (sample)
    begin
      if (!sync_if.trip)
        nxt_trip_run = 2'h0;
      else if (trip_run_ff == TRIP_LIMIT)
        nxt_trip_run = TRIP_LIMIT;
      else
        nxt_trip_run = trip_run_ff + 2'h1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      trip_run_ff <= 2'h0;
    else
      trip_run_ff <= nxt_trip_run;
  end

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      SLOHC_IDLE:
      begin
        if (sample && sync_if.trip)
          nxt_state = SLOHC_WARN;
      end
      SLOHC_WARN:
      begin
        if (sample)
        begin
          if (!sync_if.trip)
            nxt_state = SLOHC_IDLE;
          else if (nxt_trip_run == TRIP_LIMIT)
            nxt_state = SLOHC_LATCHED;
        end
      end
      SLOHC_LATCHED:
      begin
        if (sync_if.undervolt)
          nxt_state = SLOHC_DISCHARGE;
        else
          nxt_state = SLOHC_LATCHED;
      end
      SLOHC_DISCHARGE:
      begin
        if (sync_if.below_restart)
          nxt_state = SLOHC_RECHARGE;
      end
      SLOHC_RECHARGE:
      begin
        if (sync_if.above_turn_on)
          nxt_state = SLOHC_IDLE;
      end
      default:
        nxt_state = SLOHC_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      state_ff <= SLOHC_RECHARGE;
    else
      state_ff <= nxt_state;
  end

  // power switch enable registered from next state
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      switch_en_ff <= SLOHC_RST_SWITCH_EN;
    else
      switch_en_ff <= switching_allowed(nxt_state);
  end

  // start-up source enable registered from next state
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      startup_src_en_ff <= SLOHC_RST_STARTUP_EN;
    else
      startup_src_en_ff <= charging(nxt_state);
  end

  // warning indication registered from next state
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      warning_ff <= 1'b0;
    else
      warning_ff <= warned(nxt_state);
  end

  // fault latch indication registered from next state
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      fault_latched_ff <= 1'b0;
    else
      fault_latched_ff <= latched(nxt_state);
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      trip_flag_ff <= 1'b0;
    else
      trip_flag_ff <= sample & sync_if.trip;
  end

  assign switch_en_out      = switch_en_ff;
  assign startup_src_en_out = startup_src_en_ff;
  assign warning_out        = warning_ff;
  assign fault_latched_out  = fault_latched_ff;
  assign trip_flag_out      = trip_flag_ff;
endmodule

// ---- slohc_top_properties.sv ----
// port assertions for the hiccup block
`timescale 1ns/1ps
module slohc_top_properties (
  input logic clk_in,
  input logic rst_in,
  input logic undervolt_in,
  input logic switch_en_out,
  input logic startup_src_en_out,
  input logic warning_out,
  input logic fault_latched_out,
  input logic trip_flag_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  latch_off_a: assert property (fault_latched_out |-> !switch_en_out)
    else $error("switch on while latched");
  warn_entry_a: assert property ($rose(warning_out) |-> trip_flag_out)
    else $error("warning without trip");
  warn_exit_a: assert property ($fell(warning_out) |-> fault_latched_out == trip_flag_out)
    else $error("bad warning exit");
  fault_entry_a: assert property ($rose(fault_latched_out) |-> $past(warning_out))
    else $error("latch without warning");
  switch_off_a: assert property ($fell(switch_en_out) |-> fault_latched_out)
    else $error("switch off without fault");
  latch_clear_a: assert property ($fell(fault_latched_out) |-> $past(undervolt_in, 2))
    else $error("latch cleared early");
  src_off_a: assert property (fault_latched_out |-> !startup_src_en_out)
    else $error("source on while latched");
  src_excl_a: assert property (startup_src_en_out |-> !switch_en_out)
    else $error("switching while charging");
endmodule
bind slohc_top slohc_top_properties slohc_top_properties_i (.clk_in, .rst_in, .undervolt_in, .switch_en_out,
  .startup_src_en_out, .warning_out, .fault_latched_out, .trip_flag_out);

// ---- slohc_supply.sv ----
// supply capacitor and comparator model
`timescale 1ns/1ps
module slohc_supply (
  input  logic clk_in,
  input  logic switch_in,
  input  logic charge_in,
  output logic low_out,
  output logic restart_out,
  output logic on_out
);
  int vdd_ff = 0;
  always_ff @(posedge clk_in)
  begin
    if (charge_in)
      vdd_ff <= vdd_ff + 1;
    else if (!switch_in && vdd_ff > 0)
      vdd_ff <= vdd_ff - 1;
  end
  assign low_out = vdd_ff <= 20;
  assign restart_out = vdd_ff < 10;
  assign on_out = vdd_ff >= 40;
endmodule

// ---- slohc_top_bench.sv ----
// self-checking bench for the hiccup block
`timescale 1ns/1ps
module slohc_top_bench;
  logic clk_in = 1'b0, rst_in = 1'b1, oc2_trip_in = 1'b0, on_time_end_in = 1'b0;
  logic undervolt_in, below_restart_in, above_turn_on_in;
  logic switch_en_out, startup_src_en_out, warning_out, fault_latched_out, trip_flag_out;
  int   mismatches = 0, tests_run = 0;
  always #10 clk_in = ~clk_in;
  slohc_top slohc_top_i (.clk_in, .rst_in, .oc2_trip_in, .on_time_end_in, .undervolt_in, .below_restart_in,
    .above_turn_on_in, .switch_en_out, .startup_src_en_out, .warning_out, .fault_latched_out, .trip_flag_out);
  slohc_supply slohc_supply_i (.clk_in, .switch_in(switch_en_out), .charge_in(startup_src_en_out),
    .low_out(undervolt_in), .restart_out(below_restart_in), .on_out(above_turn_on_in));
  task automatic print_verdict();
    if (mismatches == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic got, input logic exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %0t: got %b", $time, got);
    end
  endtask
  task automatic cyc(input logic trip);
    oc2_trip_in = trip;
    on_time_end_in = 1'b1;
    repeat (3) @(posedge clk_in);
    #1 chk(trip_flag_out, trip);
    @(posedge clk_in);
    #1 chk(trip_flag_out, 1'b0);
    on_time_end_in = 1'b0;
    repeat (4) @(posedge clk_in);
    #1;
  endtask
  task automatic wait_for(ref logic s, input logic exp);
    for (int n = 0; n < 200 && s !== exp; n++)
      @(posedge clk_in) #1;
    chk(s, exp);
  endtask
  task automatic t_disturb();
    cyc(1'b1);
    chk(warning_out, 1'b1);
    cyc(1'b0);
    chk(warning_out, 1'b0);
    chk(switch_en_out, 1'b1);
  endtask
  task automatic t_reset();
    rst_in = 1'b1;
    @(posedge clk_in);
    #1 chk(switch_en_out, slohc_pkg::SLOHC_RST_SWITCH_EN);
    chk(startup_src_en_out, slohc_pkg::SLOHC_RST_STARTUP_EN);
    chk(fault_latched_out, 1'b0);
    rst_in = 1'b0;
    wait_for(switch_en_out, 1'b1);
  endtask
  task automatic t_fault();
    cyc(1'b1);
    cyc(1'b1);
    chk(fault_latched_out, 1'b1);
    wait_for(fault_latched_out, 1'b0);
    chk(startup_src_en_out, 1'b0);
    wait_for(startup_src_en_out, 1'b1);
    wait_for(switch_en_out, 1'b1);
  endtask
  initial
  begin
    repeat (6) @(posedge clk_in);
    #1 chk(startup_src_en_out, slohc_pkg::SLOHC_RST_STARTUP_EN);
    chk(switch_en_out, slohc_pkg::SLOHC_RST_SWITCH_EN);
    chk(warning_out, 1'b0);
    rst_in = 1'b0;
    wait_for(switch_en_out, 1'b1);
    t_disturb();
    t_reset();
    t_fault();
    t_fault();
    print_verdict();
  end
  initial
  begin
    #100000;
    mismatches++;
    print_verdict();
  end
endmodule
